/* File: hdl/rrx_exec.sv */
// Decode and execution of the return instructions and rotate-left-through-carry.
// Contract
// - Return from interrupt pops the stack and loads the popped top into the PC.
// - Return from interrupt sets the high or low enable bit; with shadow bit 0, nothing else in status.
// - With shadow bit 1 it restores accumulator, flags and bank select from shadows.
// - Return with literal loads its 8-bit immediate into the accumulator.
// - Return with literal also pops the stack into the PC.
// - No return instruction changes the PC upper or high latch registers.
// - Return from subroutine pops the stack into the PC and, with shadow bit 0, changes no flag.
// - Its shadow bit 1 restores accumulator, flags, bank select; 0 leaves them.
// - Rotate shifts byte left, bit 7 to carry, carry to bit 0; sets C, N, Z.
// - Rotate destination 0 writes the accumulator, 1 writes the source register.
// - Rotate access 0 uses the access bank, 1 uses the bank select register.
// - Extended set with access 0 uses indexed offset when the address is at most 95.
`timescale 1ns/10ps

module rrx_exec
  import rrx_pkg::*;
#(
  parameter int QDIV = rrx_pkg::QDIV_DEFAULT
)
(
  // Clock and reset.
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  // Instruction fetch.
  input  wire logic                          instr_valid,
  input  wire logic [rrx_pkg::INSN_W-1:0]    instr_word,
  output logic                               instr_ready,
  output logic      [1:0]                    q_phase,
  // Return stack.
  input  wire logic [rrx_pkg::PC_W-1:0]      stack_top_value,
  output logic                               stack_pop,
  output logic                               pc_load,
  output logic      [rrx_pkg::PC_W-1:0]      pc_value,
  // Data memory.
  output logic                               mem_rd_en,
  output logic      [rrx_pkg::ADDR_W-1:0]    mem_rd_addr,
  input  wire logic [rrx_pkg::DATA_W-1:0]    mem_rdata,
  output rrx_pkg::rrx_mem_wr_t               mem_wr,
  // Mode and indexing.
  input  wire logic                          ext_set_en,
  input  wire logic [rrx_pkg::ADDR_W-1:0]    index_base,
  // Shadow copies and live core registers.
  input  rrx_pkg::rrx_core_regs_t            shadow_regs,
  output rrx_pkg::rrx_core_regs_t            live_regs,
  // Program counter latches.
  input  wire logic                          latch_wr_en,
  input  wire logic [rrx_pkg::DATA_W-1:0]    latch_upper_wdata,
  input  wire logic [rrx_pkg::DATA_W-1:0]    latch_high_wdata,
  output logic      [rrx_pkg::DATA_W-1:0]    pc_upper_latch,
  output logic      [rrx_pkg::DATA_W-1:0]    pc_high_latch,
  // Interrupt enables.
  input  wire logic                          int_level_high,
  input  wire logic                          int_clear_high,
  input  wire logic                          int_clear_low,
  output logic                               high_priority_int_enable,
  output logic                               low_priority_int_enable
);

  import rrx_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_NOP
  } rrx_state_t;

  localparam int DIV_W = (QDIV > 1) ? $clog2(QDIV) : 1;

  rrx_state_t            state;
  rrx_op_t               op;
  logic [INSN_W-1:0]     insn;
  logic                  is_ret_int;
  logic [DIV_W-1:0]      div_cnt;
  logic                  q_tick;
  logic                  decode_now;
  logic                  q4_exec;
  rrx_op_t               next_op;
  logic [ADDR_W-1:0]     rot_addr;
  logic [DATA_W-1:0]     rot_result;
  logic                  rot_c;
  logic                  rot_n;
  logic                  rot_z;
  logic                  restore;

  // Quarter-cycle divider; q_tick marks the last clock of each quarter.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= '0;
      q_phase <= Q1;
    end else if (q_tick) begin
      div_cnt <= '0;
      q_phase <= q_phase + 2'h1;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  assign q_tick     = (div_cnt == DIV_W'(QDIV - 1));
  assign decode_now = q_tick && (q_phase == Q1) && (state == ST_IDLE) && instr_valid;
  assign q4_exec    = q_tick && (q_phase == Q4) && (state == ST_EXEC);
  assign restore    = (op == OP_RET) && insn[SHADOW_BIT];

  always_comb begin
    if ((instr_word & RET_INT_MASK) == RET_INT_PAT) begin
      next_op = OP_RET;
    end else if ((instr_word & RETURN_MASK) == RETURN_PAT) begin
      next_op = OP_RET;
    end else if ((instr_word & RET_LIT_MASK) == RET_LIT_PAT) begin
      next_op = OP_RET_LIT;
    end else if ((instr_word & ROT_CARRY_MASK) == ROT_CARRY_PAT) begin
      next_op = OP_ROT;
    end else begin
      next_op = OP_NONE;
    end
  end

  rrx_rotate_unit u_rotate (
    .file_addr            (insn[DATA_W-1:0]),
    .access_sel           (insn[ACCESS_BIT]),
    .ext_set_en           (ext_set_en),
    .bank_select_register (live_regs.bank),
    .index_base           (index_base),
    .operand              (mem_rdata),
    .carry_in             (live_regs.flags[FLAG_C]),
    .mem_addr             (rot_addr),
    .result               (rot_result),
    .carry_out            (rot_c),
    .negative             (rot_n),
    .zero                 (rot_z)
  );

  // Sequencing: decode at the end of Q1, finish at Q4, then an idle cycle for returns.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      op          <= OP_NONE;
      insn        <= '0;
      is_ret_int  <= 1'b0;
      instr_ready <= 1'b1;
    end else if (decode_now) begin
      insn        <= instr_word;
      op          <= next_op;
      is_ret_int  <= ((instr_word & RET_INT_MASK) == RET_INT_PAT);
      state       <= (next_op == OP_NONE) ? ST_IDLE : ST_EXEC;
      instr_ready <= (next_op == OP_NONE);
    end else if (q4_exec) begin
      if ((op == OP_RET) || (op == OP_RET_LIT)) begin
        state <= ST_NOP;
      end else begin
        state       <= ST_IDLE;
        instr_ready <= 1'b1;
      end
    end else if (q_tick && (q_phase == Q4) && (state == ST_NOP)) begin
      state       <= ST_IDLE;
      instr_ready <= 1'b1;
    end
  end

  // Stack pop and program counter load just after Q4 of the first cycle, in Q1 of the next.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stack_pop <= 1'b0;
      pc_load   <= 1'b0;
      pc_value  <= PC_RESET;
    end else if (q4_exec && ((op == OP_RET) || (op == OP_RET_LIT))) begin
      stack_pop <= 1'b1;
      pc_load   <= 1'b1;
      pc_value  <= stack_top_value;
    end else begin
      stack_pop <= 1'b0;
      pc_load   <= 1'b0;
    end
  end

  // Data memory read in Q3 and write-back of the rotate result after Q4.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_rd_en   <= 1'b0;
      mem_rd_addr <= '0;
      mem_wr      <= '0;
    end else begin
      mem_rd_en    <= q_tick && (q_phase == Q2) && (state == ST_EXEC) && (op == OP_ROT);
      mem_wr.wr_en <= q4_exec && (op == OP_ROT) && insn[DEST_BIT];
      if (q_tick && (q_phase == Q2) && (state == ST_EXEC) && (op == OP_ROT)) begin
        mem_rd_addr <= rot_addr;
      end
      if (q4_exec && (op == OP_ROT)) begin
        mem_wr.addr <= rot_addr;
        mem_wr.data <= rot_result;
      end
    end
  end

  // Accumulator, flags and bank select.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      live_regs.acc   <= ACC_RESET;
      live_regs.flags <= FLAG_RESET;
      live_regs.bank  <= BANK_RESET;
    end else if (q4_exec) begin
      if (restore) begin
        live_regs <= shadow_regs;
      end else if (op == OP_RET_LIT) begin
        live_regs.acc <= insn[DATA_W-1:0];
      end else if (op == OP_ROT) begin
        live_regs.flags[FLAG_C] <= rot_c;
        live_regs.flags[FLAG_N] <= rot_n;
        live_regs.flags[FLAG_Z] <= rot_z;
        if (!insn[DEST_BIT]) begin
          live_regs.acc <= rot_result;
        end
      end
    end
  end

  // Program counter latches are written only by their own port, never by a return.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc_upper_latch <= '0;
      pc_high_latch  <= '0;
    end else if (latch_wr_en) begin
      pc_upper_latch <= latch_upper_wdata;
      pc_high_latch  <= latch_high_wdata;
    end
  end

  // Interrupt enables; a set from a return wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      high_priority_int_enable <= 1'b0;
      low_priority_int_enable  <= 1'b0;
    end else begin
      if (q4_exec && is_ret_int && int_level_high) begin
        high_priority_int_enable <= 1'b1;
      end else if (int_clear_high) begin
        high_priority_int_enable <= 1'b0;
      end
      if (q4_exec && is_ret_int && !int_level_high) begin
        low_priority_int_enable <= 1'b1;
      end else if (int_clear_low) begin
        low_priority_int_enable <= 1'b0;
      end
    end
  end

endmodule

/* File: hdl/rrx_pkg.sv */
// Shared constants and types for the return and rotate execution block.
package rrx_pkg;

  localparam int PC_W   = 21;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int FLAG_W = 5;
  localparam int INSN_W = 16;

  // Opcode patterns and masks.
  localparam logic [INSN_W-1:0] RET_INT_PAT    = 16'h0010;
  localparam logic [INSN_W-1:0] RET_INT_MASK   = 16'hFFFE;
  localparam logic [INSN_W-1:0] RETURN_PAT     = 16'h0012;
  localparam logic [INSN_W-1:0] RETURN_MASK    = 16'hFFFE;
  localparam logic [INSN_W-1:0] RET_LIT_PAT    = 16'h0C00;
  localparam logic [INSN_W-1:0] RET_LIT_MASK   = 16'hFF00;
  localparam logic [INSN_W-1:0] ROT_CARRY_PAT  = 16'h3400;
  localparam logic [INSN_W-1:0] ROT_CARRY_MASK = 16'hFC00;

  // Operand field positions.
  localparam int SHADOW_BIT = 0;
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;
  localparam int MSB_BIT    = 7;

  // Flag positions inside the flags register.
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  // Access bank split and indexed literal offset limit.
  localparam logic [DATA_W-1:0] INDEXED_MAX  = 8'h5F;
  localparam logic [BANK_W-1:0] ACC_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK  = 4'hF;

  // Quarter phases and reset values.
  localparam int                QDIV_DEFAULT = 1;
  localparam logic [1:0]        Q1 = 2'h0;
  localparam logic [1:0]        Q2 = 2'h1;
  localparam logic [1:0]        Q3 = 2'h2;
  localparam logic [1:0]        Q4 = 2'h3;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h00;
  localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
  localparam logic [PC_W-1:0]   PC_RESET   = 21'h000000;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [FLAG_W-1:0] flags;
    logic [BANK_W-1:0] bank;
  } rrx_core_regs_t;

  typedef struct packed {
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rrx_mem_wr_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_RET,
    OP_RET_LIT,
    OP_ROT
  } rrx_op_t;

endpackage

/* File: hdl/rrx_rotate_unit.sv */
// Address formation and rotate-through-carry arithmetic for the rotate instruction.
`timescale 1ns/10ps

module rrx_rotate_unit
  import rrx_pkg::*;
(
  // Instruction operands.
  input  wire logic [rrx_pkg::DATA_W-1:0] file_addr,
  input  wire logic                       access_sel,
  input  wire logic                       ext_set_en,
  // Context.
  input  wire logic [rrx_pkg::BANK_W-1:0] bank_select_register,
  input  wire logic [rrx_pkg::ADDR_W-1:0] index_base,
  input  wire logic [rrx_pkg::DATA_W-1:0] operand,
  input  wire logic                       carry_in,
  // Results.
  output logic      [rrx_pkg::ADDR_W-1:0] mem_addr,
  output logic      [rrx_pkg::DATA_W-1:0] result,
  output logic                            carry_out,
  output logic                            negative,
  output logic                            zero
);

  import rrx_pkg::*;

  always_comb begin
    if (access_sel) begin
      mem_addr = {bank_select_register, file_addr};
    end else if (ext_set_en && (file_addr <= INDEXED_MAX)) begin
      mem_addr = index_base + {{(ADDR_W-DATA_W){1'b0}}, file_addr};
    end else if (file_addr <= INDEXED_MAX) begin
      mem_addr = {ACC_LOW_BANK, file_addr};
    end else begin
      mem_addr = {ACC_HI_BANK, file_addr};
    end
  end

  always_comb begin
    result    = {operand[DATA_W-2:0], carry_in};
    carry_out = operand[MSB_BIT];
    negative  = result[MSB_BIT];
    zero      = (result == '0);
  end

endmodule

/* File: verification/rrx_exec_bench.sv */
// Self-checking bench for the return and rotate execution block.
`timescale 1ns/10ps

module rrx_exec_bench;
  import rrx_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0, latch_wr_en = 1'b0;
  logic int_level_high = 1'b1, int_clear_high = 1'b0, int_clear_low = 1'b0;
  logic [INSN_W-1:0] instr_word = 16'h0000;
  logic [ADDR_W-1:0] index_base = 12'h100;
  logic [DATA_W-1:0] latch_upper_wdata = 8'h5A, latch_high_wdata = 8'hA5;
  rrx_core_regs_t    shadow_regs = {8'h3C, 5'h11, 4'h3};
  logic instr_ready, stack_pop, pc_load, mem_rd_en, high_priority_int_enable, low_priority_int_enable;
  logic [1:0] q_phase;
  logic [PC_W-1:0] stack_top_value, pc_value;
  logic [ADDR_W-1:0] mem_rd_addr;
  logic [DATA_W-1:0] mem_rdata, pc_upper_latch, pc_high_latch, res;
  rrx_mem_wr_t mem_wr;
  rrx_core_regs_t live_regs;
  int mismatches = 0, checks_done = 0, cycles = 0, pops = 0, writes = 0;
  logic c;
  logic [7:0] tf [5] = '{8'h10, 8'h20, 8'h5F, 8'h60, 8'h5F};
  logic [7:0] td [5] = '{8'hE6, 8'h80, 8'h7F, 8'h80, 8'h01};
  logic [11:0] ta [5] = '{12'h510, 12'h020, 12'h15F, 12'hF60, 12'h05F};
  logic [4:0] tm [5] = '{5'h0C, 5'h00, 5'h09, 5'h09, 5'h00};

  rrx_exec #(.QDIV(1)) dut (.clk_sys, .rstn, .instr_valid, .instr_word, .instr_ready, .q_phase,
    .stack_top_value, .stack_pop, .pc_load, .pc_value, .mem_rd_en, .mem_rd_addr, .mem_rdata,
    .mem_wr, .ext_set_en, .index_base, .shadow_regs, .live_regs, .latch_wr_en,
    .latch_upper_wdata, .latch_high_wdata, .pc_upper_latch, .pc_high_latch, .int_level_high,
    .int_clear_high, .int_clear_low, .high_priority_int_enable, .low_priority_int_enable);
  rrx_far_side_model model (.clk_sys, .stack_pop, .stack_top_value, .mem_rd_en, .mem_rd_addr,
    .mem_rdata, .mem_wr);

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (stack_pop)
      pops <= pops + 1;
    if (mem_wr.wr_en)
      writes <= writes + 1;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [PC_W-1:0] top_of(input int k);
    return 21'h10000 + 21'(k * 21'h111);
  endfunction

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Offers one word at the end of Q1 and waits until the block is idle again.
  task run(input logic [INSN_W-1:0] w);
    int n;
    n = 0;
    while (!(instr_ready === 1'b1 && q_phase === Q1) && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    while (instr_ready !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task results();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++)
      model.stk[i] = top_of(i);
    model.sp = 3'h7;
    latch_wr_en = 1'b1;
    @(negedge clk_sys);
    latch_wr_en = 1'b0;
    run(16'h0011);
    check("pc", top_of(7), pc_value);
    check("live", {8'h3C, 5'h11, 4'h3}, live_regs);
    check("enables", 2'h2, {high_priority_int_enable, low_priority_int_enable});
    shadow_regs = {8'h96, 5'h00, 4'h5};
    int_level_high = 1'b0;
    int_clear_high = 1'b1;
    @(negedge clk_sys);
    int_clear_high = 1'b0;
    run(16'h0010);
    check("pc", top_of(6), pc_value);
    check("live", {8'h3C, 5'h11, 4'h3}, live_regs);
    check("enables", 2'h1, {high_priority_int_enable, low_priority_int_enable});
    run(16'h0012);
    check("pc", top_of(5), pc_value);
    check("live", {8'h3C, 5'h11, 4'h3}, live_regs);
    run(16'h0013);
    check("pc", top_of(4), pc_value);
    check("live", {8'h96, 5'h00, 4'h5}, live_regs);
    run(16'h0CC3);
    check("pc", top_of(3), pc_value);
    check("live", {8'hC3, 5'h00, 4'h5}, live_regs);
    check("latches", 16'h5AA5, {pc_upper_latch, pc_high_latch});
    run(16'hFFFF);
    check("pops", 32'h5, pops);
    c = 1'b0;
    for (int i = 0; i < 5; i++) begin
      model.mem[ta[i]] = td[i];
      ext_set_en = tm[i][0];
      res = {td[i][6:0], c};
      c = td[i][7];
      run({6'h0D, tm[i][3], tm[i][2], tf[i]});
      check("read address", ta[i], mem_rd_addr);
      check("flags", {res[7], 1'b0, res == 8'h00, 1'b0, c}, live_regs.flags);
      check("write strobe", tm[i][3], mem_wr.wr_en);
      if (tm[i][3])
        check("write", {ta[i], res}, {mem_wr.addr, mem_wr.data});
      else
        check("accumulator", res, live_regs.acc);
    end
    check("writes", 32'h3, writes);
    results();
  end
endmodule

/* File: verification/rrx_exec_monitor.sv */
// Checker for the return and rotate execution block.
`timescale 1ns/10ps

module rrx_exec_monitor
  import rrx_pkg::*;
#(
  parameter int QDIV = 1
)
(
  // Clock, reset and sequencing.
  input wire logic                        clk_sys,
  input wire logic                        rstn,
  input wire logic [1:0]                  q_phase,
  input wire logic                        instr_ready,
  // Stack, memory and registers.
  input wire logic [rrx_pkg::PC_W-1:0]    stack_top_value,
  input wire logic                        stack_pop,
  input wire logic                        pc_load,
  input wire logic [rrx_pkg::PC_W-1:0]    pc_value,
  input wire logic                        mem_rd_en,
  input wire logic [rrx_pkg::ADDR_W-1:0]  mem_rd_addr,
  input wire logic [rrx_pkg::DATA_W-1:0]  mem_rdata,
  input rrx_pkg::rrx_mem_wr_t             mem_wr,
  input rrx_pkg::rrx_core_regs_t          live_regs,
  input wire logic                        latch_wr_en,
  input wire logic [rrx_pkg::DATA_W-1:0]  pc_upper_latch,
  input wire logic [rrx_pkg::DATA_W-1:0]  pc_high_latch,
  input wire logic                        high_priority_int_enable,
  input wire logic                        low_priority_int_enable
);
  import rrx_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_pop_loads_pc: assert property (
    stack_pop |-> pc_load && pc_value == $past(stack_top_value))
    else $error("pop without matching pc load");
  a_return_length: assert property (
    (QDIV == 1 && stack_pop) |-> !instr_ready [*4] ##1 instr_ready)
    else $error("return length wrong");
  a_latch_hold: assert property (
    !latch_wr_en |=> $stable(pc_upper_latch) && $stable(pc_high_latch))
    else $error("pc latch changed without write");
  a_enable_on_pop: assert property (
    ($rose(high_priority_int_enable) || $rose(low_priority_int_enable)) |-> stack_pop)
    else $error("enable set outside a return");
  a_quarter_step: assert property (
    QDIV == 1 |=> q_phase == $past(q_phase) + 2'h1)
    else $error("quarter phase did not advance");
  a_rotate_result: assert property (
    mem_wr.wr_en |-> mem_wr.addr == mem_rd_addr
      && mem_wr.data == {$past(mem_rdata[6:0]), $past(live_regs.flags[FLAG_C])})
    else $error("rotate write wrong");
  a_rotate_flags: assert property (
    mem_wr.wr_en |-> live_regs.flags[FLAG_C] == $past(mem_rdata[7])
      && live_regs.flags[FLAG_N] == mem_wr.data[7]
      && live_regs.flags[FLAG_Z] == (mem_wr.data == 8'h00))
    else $error("rotate flags wrong");
  a_write_after_read: assert property (
    mem_wr.wr_en |-> $past(mem_rd_en, 2))
    else $error("write without read");
endmodule

bind rrx_exec rrx_exec_monitor #(.QDIV(QDIV)) u_monitor (.clk_sys, .rstn, .q_phase, .instr_ready,
  .stack_top_value, .stack_pop, .pc_load, .pc_value, .mem_rd_en, .mem_rd_addr, .mem_rdata, .mem_wr,
  .live_regs, .latch_wr_en, .pc_upper_latch, .pc_high_latch, .high_priority_int_enable,
  .low_priority_int_enable);

/* File: verification/rrx_far_side_model.sv */
// Behavioural return stack and data memory facing the execution block.
`timescale 1ns/10ps

module rrx_far_side_model
  import rrx_pkg::*;
(
  // Clock and stack.
  input  wire logic                        clk_sys,
  input  wire logic                        stack_pop,
  output logic      [rrx_pkg::PC_W-1:0]    stack_top_value,
  // Data memory.
  input  wire logic                        mem_rd_en,
  input  wire logic [rrx_pkg::ADDR_W-1:0]  mem_rd_addr,
  output logic      [rrx_pkg::DATA_W-1:0]  mem_rdata,
  input  rrx_pkg::rrx_mem_wr_t             mem_wr
);
  import rrx_pkg::*;

  logic [PC_W-1:0]   stk [8];
  logic [2:0]        sp;
  logic [DATA_W-1:0] mem [4096];

  assign stack_top_value = stk[sp];
  initial mem_rdata = 8'h5A;
  always @(posedge clk_sys) begin
    if (stack_pop)
      sp <= sp - 3'h1;
    if (mem_rd_en)
      mem_rdata <= mem[mem_rd_addr];
    if (mem_wr.wr_en)
      mem[mem_wr.addr] <= mem_wr.data;
  end
endmodule
